// *** logic/nasi_params.svh ***
`ifndef NASI_PARAMS_SVH
`define NASI_PARAMS_SVH
`define NASI_CTRL_OFS 8'h00
`define NASI_CODE_OFS 8'h04
`define NASI_ENCCMD_OFS 8'h08
`define NASI_STATUS_OFS 8'h0C
`define NASI_MTURN_OFS 8'h10
`define NASI_STURN_OFS 8'h14
`define NASI_INT_STAT_OFS 8'h18
`define NASI_INT_EN_OFS 8'h1C
`define NASI_INT_CLR_OFS 8'h20
`define NASI_CTRL_LINK_LSB 0
`define NASI_CTRL_DISP_LSB 4
`define NASI_CTRL_ALM_BIT 8
`define NASI_CTRL_WRN_BIT 9
`define NASI_CODE_WRN_LSB 8
`define NASI_CMD_NET_BIT 0
`define NASI_CMD_LOCAL_BIT 1
`define NASI_EV_ADDR 0
`define NASI_EV_CLR_DONE 1
`define NASI_EV_CLR_REFUSED 2
`define NASI_EV_ALM_VALID 3
`define NASI_CTRL_RST 32'h0000_0000
`define NASI_INT_EN_RST 4'h0
`define NASI_ADDR_OFFSET 8'h40
`define NASI_SW_MIN 8'h01
`define NASI_SW_MAX 8'h1F
`define NASI_CODE_ADDR 8'h82
`define NASI_CODE_CMD 8'h27
`define NASI_CODE_COMM 8'h83
`define NASI_CODE_CYC 8'h84
`define NASI_CODE_WDOG 8'h86
`define NASI_CODE_CYCSET 8'h90
`define NASI_CODE_SYNC 8'h91
`define NASI_CODE_ERR 8'hEE
`define NASI_CLK_KHZ 100000
`define NASI_INIT_MS 2000
`define NASI_NODE_SHOW_MS 1000
`define NASI_BLINK_HALF_MS 250
`define NASI_SYNC_FILL 2'h3
`endif

// *** logic/nasi_pkg.sv ***
package nasi_pkg;
    typedef enum logic [1:0] {
        NASI_LINK_NONE,
        NASI_LINK_ASYNC,
        NASI_LINK_SYNC
    } nasi_link_t;
    typedef enum logic [2:0] {
        NASI_DISP_NODE,
        NASI_DISP_DEFAULT,
        NASI_DISP_ALARM,
        NASI_DISP_WARN,
        NASI_DISP_ERROR
    } nasi_disp_mode_t;
    typedef struct packed {
        logic red;
        logic green;
    } nasi_led_t;
    typedef struct packed {
        nasi_disp_mode_t mode;
        logic [3:0] sel;
        logic [7:0] code;
    } nasi_disp_t;
endpackage : nasi_pkg

// *** logic/nasi_blink.sv ***
`timescale 1ns/1ns
module nasi_blink #(
    parameter int unsigned HALF_CYCLES = 25000000
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic blink
);
    logic [31:0] cnt_ff;
    logic blink_ff;

    // 50 percent duty square wave
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 32'h0000_0000;
            blink_ff <= 1'b0;
        end else if (cnt_ff >= HALF_CYCLES - 1) begin
            cnt_ff <= 32'h0000_0000;
            blink_ff <= ~blink_ff; // (RULE14)
        end else begin
            cnt_ff <= cnt_ff + 32'h0000_0001;
        end
    end

    assign blink = blink_ff;
endmodule : nasi_blink

// *** logic/nasi_top.sv ***
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ns
`include "nasi_params.svh"
// Summary of operation
// (RULE1) The switch is sampled once at power-on and later changes are ignored.
// (RULE2) A switch value of 1 to 31 gives node address value plus 40h.
// (RULE3) A switch value outside 1 to 31 raises alarm code 82.
// (RULE4) The link lamp is off, flashing green, or steady green by link state.
// (RULE5) Recoverable link alarms 83 84 86 90 91 flash the link lamp red.
// (RULE6) The link lamp is steady red for the address alarm 82.
// (RULE7) Non-link alarms never alter the link lamp.
// (RULE8) The alarm output is only valid about 2 s after power-on.
// (RULE9) At power-on the display shows the node address, then the default.
// (RULE10) The display shows an active alarm code, else a warning code.
// (RULE11) An encoder clear zeroes the multi-turn count and keeps single-turn.
// (RULE12) A local encoder clear raises command error 27 until power cycle.
// (RULE13) A clear with an incremental encoder is refused with an error.
// (RULE14) Flashing lamps toggle at about 2 Hz with 50 percent duty.
module nasi_top #(
    parameter int unsigned INIT_CYCLES =
        `NASI_INIT_MS * (`NASI_CLK_KHZ),
    parameter int unsigned NODE_SHOW_CYCLES =
        `NASI_NODE_SHOW_MS * (`NASI_CLK_KHZ),
    parameter int unsigned BLINK_HALF_CYCLES =
        `NASI_BLINK_HALF_MS * (`NASI_CLK_KHZ),
    parameter int unsigned SW_W = 8,
    parameter int unsigned MTURN_W = 16,
    parameter int unsigned STURN_W = 17
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [SW_W-1:0] node_switch,
    input wire logic absolute_encoder_option,
    input wire logic enc_turn_up,
    input wire logic enc_turn_down,
    input wire logic [STURN_W-1:0] enc_single_turn,
    output nasi_pkg::nasi_led_t link_status_led,
    output nasi_pkg::nasi_disp_t code_display,
    output logic alarm_out_n,
    output logic [7:0] node_address,
    output logic irq
);
    import nasi_pkg::*;

    logic [SW_W-1:0] sw_meta_ff, sw_sync_ff;
    logic abs_meta_ff, abs_sync_ff;
    logic [1:0] fill_ff;
    logic sampled_ff;
    logic [SW_W-1:0] sw_val_ff;
    logic [7:0] node_addr_ff;
    logic addr_alarm_ff;
    logic cmd_alarm_ff;
    logic clr_err_ff;
    logic [MTURN_W-1:0] mturn_ff;
    logic [STURN_W-1:0] sturn_ff;
    logic [31:0] init_cnt_ff;
    logic init_done_ff;
    logic [31:0] show_cnt_ff;
    logic show_done_ff;
    logic [31:0] ctrl_ff;
    logic [15:0] code_ff;
    logic [3:0] int_stat_ff, int_en_ff;
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    nasi_led_t led_ff, nxt_led;
    nasi_disp_t disp_ff, nxt_disp;
    logic alarm_n_ff;
    logic irq_ff;
    logic blink;
    logic wr_en, known;
    logic clr_req, clr_net, clr_local;
    logic init_pulse;
    logic [3:0] ev;
    nasi_link_t link_state;
    logic sw_alarm, sw_warn, link_alarm, alarm_any;
    logic [7:0] sw_alarm_code;

    nasi_blink #(
        .HALF_CYCLES(BLINK_HALF_CYCLES)
    ) nasi_blink_i (
        .pclk(pclk),
        .presetn(presetn),
        .blink(blink)
    );

    // apb decode, zero wait states
    assign wr_en = psel && penable && pwrite;
    always_comb begin
        case (paddr)
            `NASI_CTRL_OFS, `NASI_CODE_OFS, `NASI_ENCCMD_OFS,
            `NASI_STATUS_OFS, `NASI_MTURN_OFS, `NASI_STURN_OFS,
            `NASI_INT_STAT_OFS, `NASI_INT_EN_OFS,
            `NASI_INT_CLR_OFS: known = 1'b1;
            default: known = 1'b0;
        endcase
    end

    assign clr_net = wr_en && paddr == `NASI_ENCCMD_OFS &&
        pwdata[`NASI_CMD_NET_BIT];
    assign clr_local = wr_en && paddr == `NASI_ENCCMD_OFS &&
        pwdata[`NASI_CMD_LOCAL_BIT];
    assign clr_req = clr_net || clr_local;

    // switch and encoder option pins pass two flops before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_meta_ff <= '0;
            sw_sync_ff <= '0;
            abs_meta_ff <= 1'b0;
            abs_sync_ff <= 1'b0;
        end else begin
            sw_meta_ff <= node_switch;
            sw_sync_ff <= sw_meta_ff;
            abs_meta_ff <= absolute_encoder_option;
            abs_sync_ff <= abs_meta_ff;
        end
    end

    // one-shot capture once the synchroniser has filled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fill_ff <= 2'h0;
            sampled_ff <= 1'b0;
            sw_val_ff <= '0;
        end else if (!sampled_ff) begin
            if (fill_ff == `NASI_SYNC_FILL) begin
                sampled_ff <= 1'b1;
                sw_val_ff <= sw_sync_ff; // (RULE1)
            end else begin
                fill_ff <= fill_ff + 2'h1;
            end
        end
    end

    // address mapping and range check, settled once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            node_addr_ff <= 8'h00;
            addr_alarm_ff <= 1'b0;
        end else if (!sampled_ff && fill_ff == `NASI_SYNC_FILL) begin
            if (sw_sync_ff >= SW_W'(`NASI_SW_MIN) &&
                sw_sync_ff <= SW_W'(`NASI_SW_MAX)) begin
                node_addr_ff <= `NASI_ADDR_OFFSET +
                    8'(sw_sync_ff); // (RULE2)
            end else begin
                addr_alarm_ff <= 1'b1; // (RULE3)
            end
        end
    end

    // power-on hold-off for the alarm output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_cnt_ff <= 32'h0000_0000;
            init_done_ff <= 1'b0;
        end else if (!init_done_ff) begin
            if (init_cnt_ff >= INIT_CYCLES - 1) begin
                init_done_ff <= 1'b1; // (RULE8)
            end else begin
                init_cnt_ff <= init_cnt_ff + 32'h0000_0001;
            end
        end
    end
    assign init_pulse = (init_cnt_ff >= INIT_CYCLES - 1) && !init_done_ff;

    // node address shown for a while after capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            show_cnt_ff <= 32'h0000_0000;
            show_done_ff <= 1'b0;
        end else if (sampled_ff && !show_done_ff) begin
            if (show_cnt_ff >= NODE_SHOW_CYCLES - 1) begin
                show_done_ff <= 1'b1; // (RULE9)
            end else begin
                show_cnt_ff <= show_cnt_ff + 32'h0000_0001;
            end
        end
    end

    // encoder clear handling; alarm 27 only leaves at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_alarm_ff <= 1'b0;
            clr_err_ff <= 1'b0;
        end else if (clr_req) begin
            if (!abs_sync_ff) begin
                clr_err_ff <= 1'b1; // (RULE13)
            end else begin
                clr_err_ff <= 1'b0;
                if (clr_local) begin
                    cmd_alarm_ff <= 1'b1; // (RULE12)
                end
            end
        end
    end

    // multi-turn count; clear wins over a coincident turn step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mturn_ff <= '0;
        end else if (clr_req && abs_sync_ff) begin
            mturn_ff <= '0; // (RULE11)
        end else if (enc_turn_up && !enc_turn_down) begin
            mturn_ff <= mturn_ff + MTURN_W'(1);
        end else if (enc_turn_down && !enc_turn_up) begin
            mturn_ff <= mturn_ff - MTURN_W'(1);
        end
    end

    // single-turn tracks the encoder, a clear never touches it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sturn_ff <= '0;
        end else begin
            sturn_ff <= enc_single_turn; // (RULE11)
        end
    end

    // software-written control and codes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= `NASI_CTRL_RST;
            code_ff <= 16'h0000;
        end else if (wr_en && paddr == `NASI_CTRL_OFS) begin
            ctrl_ff <= pwdata;
        end else if (wr_en && paddr == `NASI_CODE_OFS) begin
            code_ff <= pwdata[15:0];
        end
    end

    always_comb begin
        case (ctrl_ff[`NASI_CTRL_LINK_LSB +: 2])
            2'h1: link_state = NASI_LINK_ASYNC;
            2'h2: link_state = NASI_LINK_SYNC;
            default: link_state = NASI_LINK_NONE;
        endcase
    end
    assign sw_alarm = ctrl_ff[`NASI_CTRL_ALM_BIT];
    assign sw_warn = ctrl_ff[`NASI_CTRL_WRN_BIT];
    assign sw_alarm_code = code_ff[7:0];
    assign link_alarm = sw_alarm &&
        (sw_alarm_code == `NASI_CODE_COMM ||
         sw_alarm_code == `NASI_CODE_CYC ||
         sw_alarm_code == `NASI_CODE_WDOG ||
         sw_alarm_code == `NASI_CODE_CYCSET ||
         sw_alarm_code == `NASI_CODE_SYNC);
    assign alarm_any = addr_alarm_ff || cmd_alarm_ff || sw_alarm;

    // lamp looks only at link alarms and the address alarm 82, so other faults leave it alone
    always_comb begin
        nxt_led = '0;
        if (addr_alarm_ff ||
            (sw_alarm && sw_alarm_code == `NASI_CODE_ADDR)) begin
            nxt_led.red = 1'b1; // (RULE6)
        end else if (link_alarm) begin
            nxt_led.red = blink; // (RULE5)
        end else begin
            case (link_state) // (RULE7)
                NASI_LINK_ASYNC: nxt_led.green = blink; // (RULE4)
                NASI_LINK_SYNC: nxt_led.green = 1'b1; // (RULE4)
                default: nxt_led.green = 1'b0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            led_ff <= '0;
        end else begin
            led_ff <= nxt_led;
        end
    end

    // alarm beats warning beats error text beats the start-up views
    always_comb begin
        nxt_disp.sel = ctrl_ff[`NASI_CTRL_DISP_LSB +: 4];
        nxt_disp.mode = NASI_DISP_DEFAULT;
        nxt_disp.code = 8'h00;
        if (addr_alarm_ff) begin
            nxt_disp.mode = NASI_DISP_ALARM;
            nxt_disp.code = `NASI_CODE_ADDR; // (RULE10)
        end else if (cmd_alarm_ff) begin
            nxt_disp.mode = NASI_DISP_ALARM;
            nxt_disp.code = `NASI_CODE_CMD; // (RULE10)
        end else if (sw_alarm) begin
            nxt_disp.mode = NASI_DISP_ALARM;
            nxt_disp.code = sw_alarm_code; // (RULE10)
        end else if (sw_warn) begin
            nxt_disp.mode = NASI_DISP_WARN;
            nxt_disp.code = code_ff[`NASI_CODE_WRN_LSB +: 8]; // (RULE10)
        end else if (clr_err_ff) begin
            nxt_disp.mode = NASI_DISP_ERROR;
            nxt_disp.code = `NASI_CODE_ERR; // (RULE13)
        end else if (!show_done_ff) begin
            nxt_disp.mode = NASI_DISP_NODE;
            nxt_disp.code = node_addr_ff; // (RULE9)
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disp_ff <= '0;
        end else begin
            disp_ff <= nxt_disp;
        end
    end

    // held low until valid so the host never sees a false ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_n_ff <= 1'b0;
        end else begin
            alarm_n_ff <= init_done_ff && !alarm_any; // (RULE8)
        end
    end

    // sticky events; a set in the clear cycle survives
    assign ev[`NASI_EV_ADDR] = !sampled_ff &&
        fill_ff == `NASI_SYNC_FILL &&
        !(sw_sync_ff >= SW_W'(`NASI_SW_MIN) &&
          sw_sync_ff <= SW_W'(`NASI_SW_MAX));
    assign ev[`NASI_EV_CLR_DONE] = clr_req && abs_sync_ff;
    assign ev[`NASI_EV_CLR_REFUSED] = clr_req && !abs_sync_ff;
    assign ev[`NASI_EV_ALM_VALID] = init_pulse;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_ff <= 4'h0;
        end else if (wr_en && paddr == `NASI_INT_CLR_OFS) begin
            int_stat_ff <= (int_stat_ff & ~pwdata[3:0]) | ev;
        end else begin
            int_stat_ff <= int_stat_ff | ev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_en_ff <= `NASI_INT_EN_RST;
        end else if (wr_en && paddr == `NASI_INT_EN_OFS) begin
            int_en_ff <= pwdata[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |((int_stat_ff | ev) & int_en_ff);
        end
    end

    // read data registered in the setup cycle, held for the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `NASI_CTRL_OFS: prdata_ff <= ctrl_ff;
                `NASI_CODE_OFS: prdata_ff <= {16'h0000, code_ff};
                `NASI_STATUS_OFS: prdata_ff <= {8'h00,
                    8'(sw_val_ff), 3'h0, abs_sync_ff, clr_err_ff,
                    cmd_alarm_ff, init_done_ff, addr_alarm_ff,
                    node_addr_ff};
                `NASI_MTURN_OFS: prdata_ff <= 32'(mturn_ff);
                `NASI_STURN_OFS: prdata_ff <= 32'(sturn_ff);
                `NASI_INT_STAT_OFS: prdata_ff <= {28'h0, int_stat_ff};
                `NASI_INT_EN_OFS: prdata_ff <= {28'h0, int_en_ff};
                default: prdata_ff <= 32'h0000_0000;
            endcase
        end else begin
            prdata_ff <= 32'h0000_0000;
        end
    end

    // unmapped addresses answer with an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_ff <= 1'b0;
        end else begin
            pslverr_ff <= psel && !penable && !known;
        end
    end

    assign prdata = prdata_ff;
    assign pready = 1'b1;
    assign pslverr = pslverr_ff;
    assign link_status_led = led_ff;
    assign code_display = disp_ff;
    assign alarm_out_n = alarm_n_ff;
    assign node_address = node_addr_ff;
    assign irq = irq_ff;
endmodule : nasi_top

// *** testbench/nasi_host_model.sv ***
`timescale 1ns/1ns
module nasi_host_model #(
    parameter int unsigned HOLD = 50
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic alarm_out_n,
    output logic host_alarm_ff
);
    int unsigned age_ff;
    // alarm pin is not trusted until the hold-off has run out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age_ff <= 0;
            host_alarm_ff <= 1'b0;
        end else begin
            if (age_ff <= HOLD) begin
                age_ff <= age_ff + 1;
            end
            host_alarm_ff <= (age_ff > HOLD) && !alarm_out_n;
        end
    end
endmodule : nasi_host_model

// *** testbench/nasi_top_assertions.sv ***
`timescale 1ns/1ns
`include "nasi_params.svh"
module nasi_chk import nasi_pkg::*; #(
    parameter int unsigned INIT_CYCLES = 50
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire nasi_pkg::nasi_led_t link_status_led,
    input wire nasi_pkg::nasi_disp_t code_display,
    input wire logic alarm_out_n,
    input wire logic [7:0] node_address
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    int unsigned cnt_ff;
    // saturates so a long run cannot wrap back into the hold-off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 0;
        end else if (cnt_ff < 100000) begin
            cnt_ff <= cnt_ff + 1;
        end
    end
    chk_node_held: assert property (
        $past(node_address) != 8'h00 |-> node_address == $past(node_address))
        else $error("node address moved after latch");
    chk_node_range: assert property (
        node_address != 8'h00 |-> node_address inside {[8'h41:8'h5F]})
        else $error("node address out of range");
    chk_addr_alarm_out: assert property (
        cnt_ff > 8 && node_address == 8'h00 |-> !alarm_out_n)
        else $error("bad switch without alarm");
    chk_red_steady: assert property (
        code_display.mode == NASI_DISP_ALARM
        && code_display.code == `NASI_CODE_ADDR |-> link_status_led == 2'b10)
        else $error("address alarm lamp not steady red");
    chk_alarm_holdoff: assert property (
        cnt_ff + 2 < INIT_CYCLES |-> !alarm_out_n)
        else $error("alarm output released too early");
    chk_node_shown: assert property (
        $rose(node_address != 8'h00) |-> code_display.mode == NASI_DISP_NODE
        [*4] ##21 code_display.mode != NASI_DISP_NODE)
        else $error("node address display timing");
    chk_cmd_alarm_holds: assert property (
        code_display.mode == NASI_DISP_ALARM
        && code_display.code == `NASI_CODE_CMD |=> code_display.mode
        == NASI_DISP_ALARM && code_display.code inside
        {`NASI_CODE_CMD, `NASI_CODE_ADDR})
        else $error("command alarm dropped");
    chk_err_code: assert property (
        code_display.mode == NASI_DISP_ERROR |->
        code_display.code == `NASI_CODE_ERR)
        else $error("error display code wrong");
    chk_blink_half: assert property (
        $fell(link_status_led.green) |-> !link_status_led.green [*4])
        else $error("green lamp half period short");
endmodule : nasi_chk
bind nasi_top nasi_chk #(.INIT_CYCLES(INIT_CYCLES)) nasi_chk_i (
    .pclk(pclk),
    .presetn(presetn),
    .link_status_led(link_status_led),
    .code_display(code_display),
    .alarm_out_n(alarm_out_n),
    .node_address(node_address)
);

// *** testbench/tb_node_address_status_indicator.sv ***
`timescale 1ns/1ns
`include "nasi_params.svh"
module tb_node_address_status_indicator;
    import nasi_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic abs_opt = 1'b1;
    logic up = 1'b0;
    logic dn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [7:0] sw = 8'h05;
    logic [31:0] pwdata = 32'h0;
    logic [16:0] sturn = 17'h0;
    logic [31:0] prdata, rd;
    logic [7:0] nad;
    logic pready, pslverr, irq, aout_n, host_alarm, err;
    nasi_led_t led;
    nasi_disp_t disp;
    logic [1:0] any_on, all_on;
    logic [1:0] lk [3] = '{2'd1, 2'd0, 2'd2};
    logic [1:0] ea [3] = '{2'b01, 2'b00, 2'b01};
    logic [1:0] eb [3] = '{2'b00, 2'b00, 2'b01};
    logic [7:0] lc [5] = '{`NASI_CODE_COMM, `NASI_CODE_CYC, `NASI_CODE_WDOG,
        `NASI_CODE_CYCSET, `NASI_CODE_SYNC};
    logic [7:0] sv [4] = '{8'h01, 8'h1F, 8'h00, 8'h20};
    logic [7:0] na [4] = '{8'h41, 8'h5F, 8'h00, 8'h00};
    int n_fail = 0;
    int checked = 0;
    always #5 pclk = ~pclk;
    nasi_top #(.INIT_CYCLES(50), .NODE_SHOW_CYCLES(20),
        .BLINK_HALF_CYCLES(4)) nasi_top_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .node_switch(sw),
        .absolute_encoder_option(abs_opt), .enc_turn_up(up),
        .enc_turn_down(dn), .enc_single_turn(sturn),
        .link_status_led(led), .code_display(disp),
        .alarm_out_n(aout_n), .node_address(nad), .irq(irq));
    nasi_host_model #(.HOLD(50)) nasi_host_model_i (.pclk(pclk),
        .presetn(presetn), .alarm_out_n(aout_n), .host_alarm_ff(host_alarm));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h not %h", $time, seen, exp);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checked %0d failed %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc
    // entered just after a rising edge; holds the request until pready
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 20) begin
            @(posedge pclk);
            k++;
        end
        if (k == 20) begin
            n_fail++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge so a following call never re-drives psel in this step
        @(posedge pclk);
    endtask : apb
    task automatic boot(input logic [7:0] s, input logic a);
        presetn <= 1'b0;
        sw <= s;
        abs_opt <= a;
        cyc(2);
        presetn <= 1'b1;
        cyc(8);
    endtask : boot
    task automatic watch;
        any_on = 2'b00;
        all_on = 2'b11;
        repeat (10) begin
            @(negedge pclk);
            any_on = any_on | led;
            all_on = all_on & led;
        end
        @(posedge pclk);
    endtask : watch
    initial begin
        #100000;
        n_fail++;
        give_verdict();
    end
    initial begin
        @(posedge pclk);
        boot(8'h05, 1'b1);
        chk(nad, 8'h45);
        chk(disp.mode, NASI_DISP_NODE);
        sw <= 8'h07;
        cyc(6);
        chk(nad, 8'h45);
        apb(1'b1, `NASI_CTRL_OFS, 32'h30);
        cyc(25);
        chk(disp.mode, NASI_DISP_DEFAULT);
        chk(disp.sel, 4'h3);
        apb(1'b0, 8'hFC, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0000_0000);
        cyc(20);
        chk(aout_n, 1'b1);
        apb(1'b0, `NASI_INT_STAT_OFS, 32'h0);
        chk({irq, rd[3]}, 2'b01);
        apb(1'b1, `NASI_INT_EN_OFS, 32'h8);
        cyc(2);
        chk(irq, 1'b1);
        apb(1'b1, `NASI_INT_CLR_OFS, 32'h8);
        cyc(2);
        chk(irq, 1'b0);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, `NASI_CTRL_OFS, {30'hC, lk[i]});
            cyc(8);
            watch();
            chk({any_on, all_on}, {ea[i], eb[i]});
        end
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, `NASI_CODE_OFS, {24'h0, lc[i]});
            apb(1'b1, `NASI_CTRL_OFS, 32'h132);
            cyc(2);
            watch();
            chk({any_on, all_on}, 4'b1000);
        end
        apb(1'b1, `NASI_CODE_OFS, 32'h16);
        cyc(3);
        chk({disp.mode, disp.code}, {NASI_DISP_ALARM, 8'h16});
        watch();
        chk(all_on, 2'b01);
        chk({aout_n, host_alarm}, 2'b01);
        apb(1'b1, `NASI_CTRL_OFS, 32'h232);
        apb(1'b1, `NASI_CODE_OFS, 32'h9500);
        cyc(3);
        chk({disp.mode, disp.code}, {NASI_DISP_WARN, 8'h95});
        apb(1'b1, `NASI_CTRL_OFS, 32'h32);
        sturn <= 17'h0ABCD;
        repeat (4) begin
            up <= 1'b1;
            @(posedge pclk);
            up <= 1'b0;
            @(posedge pclk);
        end
        dn <= 1'b1;
        @(posedge pclk);
        dn <= 1'b0;
        cyc(2);
        apb(1'b0, `NASI_MTURN_OFS, 32'h0);
        chk(rd, 32'h3);
        apb(1'b1, `NASI_ENCCMD_OFS, 32'h1);
        apb(1'b0, `NASI_MTURN_OFS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `NASI_STURN_OFS, 32'h0);
        chk(rd, 32'h0ABCD);
        apb(1'b0, `NASI_STATUS_OFS, 32'h0);
        chk(rd[10], 1'b0);
        apb(1'b1, `NASI_ENCCMD_OFS, 32'h2);
        cyc(2);
        chk({disp.mode, disp.code},
            {NASI_DISP_ALARM, `NASI_CODE_CMD});
        boot(8'h05, 1'b0);
        apb(1'b1, `NASI_ENCCMD_OFS, 32'h1);
        cyc(2);
        chk({disp.mode, disp.code},
            {NASI_DISP_ERROR, `NASI_CODE_ERR});
        apb(1'b0, `NASI_STATUS_OFS, 32'h0);
        chk(rd[11], 1'b1);
        for (int i = 0; i < 4; i++) begin
            boot(sv[i], 1'b1);
            chk(nad, na[i]);
            apb(1'b0, `NASI_STATUS_OFS, 32'h0);
            chk(rd[8], na[i] == 8'h00);
        end
        chk(led, 2'b10);
        chk(disp.code, `NASI_CODE_ADDR);
        cyc(50);
        chk({aout_n, host_alarm}, 2'b01);
        give_verdict();
    end
endmodule : tb_node_address_status_indicator
